//--- include/chan_defs.svh
`ifndef CHAN_DEFS_SVH
`define CHAN_DEFS_SVH

// ==========================================================
// Widths and receive queue depth
`define CH_DATA_W 16
`define CH_STS_W 18
`define CH_BUF_STS_W 9
`define CH_RX_DEPTH 2

// ==========================================================
// Reset values
`define CH_LEN_RST 4'h8
`define CH_BSTS_RST 9'h001

// ==========================================================
// Protocol status bit positions
`define CH_TXB_BIT 1
`define CH_TXD_BIT 2
`define CH_RXB_BIT 3
`define CH_RXD_BIT 4
`define CH_UART_FRM_BIT 6
`define CH_UART_BRK_BIT 7

// ==========================================================
// Buffer status bit positions
`define CH_RXEMPTY_BIT 0
`define CH_RXFULL_BIT 1
`define CH_OVR_BIT 3
`define CH_TXEMPTY_BIT 8

// ==========================================================
// Protocol-specific flag groups
`define CH_UART_LO_MASK 18'h00FE0
`define CH_UART_HI_MASK 18'h30000
`define CH_SPI_MASK 18'h00360
`define CH_I2C_MASK 18'h03F20
`define CH_SPI_B0 5
`define CH_SPI_B1 6
`define CH_SPI_B2 8
`define CH_SPI_B3 9
`define CH_I2C_B0 5
`define CH_I2C_HI_BASE 7

// ==========================================================
// Protocol interrupt enable bit positions
`define CH_PIE_UART_LO 1
`define CH_PIE_UART_HI 2

`endif

//--- include/chan_pkg.sv
package chan_pkg;

	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_SPI = 3'h1,
		MODE_UART = 3'h2,
		MODE_I2C = 3'h4
	} mode_t;

	typedef enum logic [1:0] {
		LN_IDLE = 2'h0,
		LN_START = 2'h1,
		LN_DATA = 2'h2,
		LN_STOP = 2'h3
	} line_state_t;

endpackage : chan_pkg

//--- include/rx_queue_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "chan_defs.svh"

interface rx_queue_if #(parameter int DATA_W = `CH_DATA_W);
	logic flush;
	logic push;
	logic [DATA_W-1:0] push_data;
	logic push_err;
	logic pop;
	logic [DATA_W-1:0] head_data;
	logic head_err;
	logic empty;
	logic full;

	modport owner (output flush, push, push_data, push_err, pop,
		input head_data, head_err, empty, full);
	modport store (input flush, push, push_data, push_err, pop,
		output head_data, head_err, empty, full);
endinterface : rx_queue_if

`default_nettype wire

//--- rtl/rx_hold_pair.sv
`timescale 1ns/1ns
`default_nettype none
`include "chan_defs.svh"

module rx_hold_pair #(
	parameter int DATA_W = `CH_DATA_W,
	parameter int DEPTH = `CH_RX_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	rx_queue_if.store q
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [DATA_W-1:0] mem_r [DEPTH];
	logic err_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] wr_nxt;
	logic [PW-1:0] rd_r;
	logic [PW-1:0] rd_nxt;
	logic [PW:0] cnt_r;
	logic [PW:0] cnt_nxt;
	logic do_push;
	logic do_pop;

	// ==========================================================
	// Oldest word always at the head
	assign q.empty = (cnt_r == '0);
	assign q.full = (cnt_r == (PW+1)'(DEPTH));
	assign q.head_data = mem_r[rd_r];
	assign q.head_err = err_r[rd_r];
	assign do_push = q.push && !q.full;
	assign do_pop = q.pop && !q.empty;

	always_comb begin
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (q.flush) begin
			wr_nxt = '0;
			rd_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (do_push) begin
				wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1);
			end
			if (do_pop) begin
				rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1);
			end
			cnt_nxt = cnt_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage needs no reset; count guards every pop, but head_data is read even when empty
	always_ff @(posedge clk) begin
		if (do_push && !q.flush) begin
			mem_r[wr_r] <= q.push_data;
			err_r[wr_r] <= q.push_err;
		end
	end
endmodule : rx_hold_pair

`default_nettype wire

//--- rtl/sample_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "chan_defs.svh"

module sample_tick_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [1:0] sample_prediv,
	output logic tick
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	// ==========================================================
	// Pre-divider: one pulse every sample_prediv+1 clocks
	always_comb begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!en) begin
			cnt_nxt = 2'h0;
		end else if (cnt_r >= sample_prediv) begin
			cnt_nxt = 2'h0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule : sample_tick_gen

`default_nettype wire

//--- rtl/serial_channel_events_dma.sv
`timescale 1ns/1ns
`default_nettype none
`include "chan_defs.svh"

module serial_channel_events_dma import chan_pkg::*; #(
	parameter int DATA_W = `CH_DATA_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] function_select,
	input wire logic protocol_enable,
	input wire logic tx_begin_irq_en,
	input wire logic tx_done_irq_en,
	input wire logic rx_begin_irq_en,
	input wire logic rx_done_irq_en,
	input wire logic [6:0] protocol_irq_enable_reg,
	input wire logic rx_overrun_irq_en,
	input wire logic dma_master_en,
	input wire logic dma_tx_req_en,
	input wire logic dma_rx_req_en,
	input wire logic [1:0] sample_prediv,
	input wire logic [4:0] sample_count,
	input wire logic [3:0] word_len,
	input wire logic lsb_first,
	input wire logic auto_flow_en,
	input wire logic wake_data_en,
	input wire logic wake_cts_en,
	input wire logic tx_wr,
	input wire logic [DATA_W-1:0] tx_wdata,
	input wire logic rx_rd,
	input wire logic [`CH_STS_W-1:0] status_clear,
	input wire logic overrun_clear,
	input wire logic [`CH_STS_W-1:0] proto_event_set,
	input wire logic data_pin_0,
	input wire logic control_pin_0,
	output logic data_pin_1,
	output logic [`CH_STS_W-1:0] protocol_status_reg,
	output logic [`CH_BUF_STS_W-1:0] buffer_status_reg,
	output logic [DATA_W-1:0] rx_data_reg,
	output logic irq_tx_begin,
	output logic irq_tx_done,
	output logic irq_rx_begin,
	output logic irq_rx_done,
	output logic irq_protocol,
	output logic dma_tx_req,
	output logic dma_rx_req,
	output logic wake_req
);
	// ==========================================================
	// Shared helpers
	function automatic logic [DATA_W-1:0] order_bits(input logic [DATA_W-1:0] raw,
			input logic [3:0] len, input logic lsb);
		logic [DATA_W-1:0] o;
		o = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (i < int'(len)) begin
				o[i] = lsb ? raw[i] : raw[int'(len) - 1 - i];
			end
		end
		return o;
	endfunction : order_bits

	mode_t mode;
	logic chan_on;
	logic uart_on;
	logic tick;
	logic [4:0] half_pt;
	logic clear_to_send_n;

	assign mode = mode_t'(function_select);
	assign chan_on = (mode != MODE_OFF);
	assign uart_on = (mode == MODE_UART) && protocol_enable;
	assign half_pt = sample_count >> 1;
	assign clear_to_send_n = control_pin_0;

	sample_tick_gen u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.en(chan_on),
		.sample_prediv(sample_prediv),
		.tick(tick)
	);

	rx_queue_if #(.DATA_W(DATA_W)) rxq ();

	rx_hold_pair #(.DATA_W(DATA_W), .DEPTH(`CH_RX_DEPTH)) u_rxq (
		.clk(clk),
		.rst_n(rst_n),
		.q(rxq)
	);

	// ==========================================================
	// Transmitter: one holding buffer feeding the shifter
	line_state_t tx_st_r, tx_st_nxt;
	logic tx_buf_v_r, tx_buf_v_nxt;
	logic [DATA_W-1:0] tx_buf_r, tx_buf_nxt;
	logic [DATA_W-1:0] tx_sh_r, tx_sh_nxt;
	logic [4:0] tx_smp_r, tx_smp_nxt;
	logic [3:0] tx_idx_r, tx_idx_nxt;
	logic [3:0] tx_len_r, tx_len_nxt;
	logic tx_lsb_r, tx_lsb_nxt;
	logic tx_pin_r, tx_pin_nxt;
	logic tx_begin_ev, tx_done_ev;
	logic tx_bit_end;

	assign tx_bit_end = tick && (tx_smp_r == sample_count);

	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_buf_v_nxt = tx_buf_v_r;
		tx_buf_nxt = tx_buf_r;
		tx_sh_nxt = tx_sh_r;
		tx_smp_nxt = tx_smp_r;
		tx_idx_nxt = tx_idx_r;
		tx_len_nxt = tx_len_r;
		tx_lsb_nxt = tx_lsb_r;
		tx_begin_ev = 1'b0;
		tx_done_ev = 1'b0;
		if (tick) begin
			tx_smp_nxt = tx_bit_end ? 5'h00 : tx_smp_r + 5'h01;
		end
		unique case (tx_st_r)
			LN_IDLE: begin
				tx_len_nxt = word_len;
				tx_lsb_nxt = lsb_first;
				tx_smp_nxt = 5'h00;
				if (uart_on && tx_buf_v_r && (!auto_flow_en || !clear_to_send_n)) begin
					tx_sh_nxt = order_bits(tx_buf_r, tx_len_r, tx_lsb_r);
					tx_buf_v_nxt = 1'b0;
					tx_begin_ev = 1'b1;
					tx_st_nxt = LN_START;
				end
			end
			LN_START: begin
				if (tx_bit_end) begin
					tx_idx_nxt = 4'h0;
					tx_st_nxt = LN_DATA;
				end
			end
			LN_DATA: begin
				if (tx_bit_end) begin
					tx_idx_nxt = tx_idx_r + 4'h1;
					if (tx_idx_r == tx_len_r - 4'h1) begin
						tx_st_nxt = LN_STOP;
					end
				end
			end
			LN_STOP: begin
				if (tx_bit_end) begin
					tx_done_ev = 1'b1;
					tx_len_nxt = word_len;
					tx_lsb_nxt = lsb_first;
					tx_st_nxt = LN_IDLE;
				end
			end
		endcase
		// A write landing with the load refills the single buffer
		if (tx_wr) begin
			tx_buf_nxt = tx_wdata;
			tx_buf_v_nxt = 1'b1;
		end
		unique case (tx_st_nxt)
			LN_START: tx_pin_nxt = 1'b0;
			LN_DATA: tx_pin_nxt = tx_sh_nxt[tx_idx_nxt];
			default: tx_pin_nxt = 1'b1;
		endcase
		if (!uart_on) begin
			tx_st_nxt = LN_IDLE;
			tx_pin_nxt = 1'b1;
		end
		if (!chan_on) begin
			tx_buf_v_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_st_r <= LN_IDLE;
			tx_buf_v_r <= 1'b0;
			tx_buf_r <= '0;
			tx_sh_r <= '0;
			tx_smp_r <= 5'h00;
			tx_idx_r <= 4'h0;
			tx_len_r <= `CH_LEN_RST;
			tx_lsb_r <= 1'b1;
			tx_pin_r <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_buf_v_r <= tx_buf_v_nxt;
			tx_buf_r <= tx_buf_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_smp_r <= tx_smp_nxt;
			tx_idx_r <= tx_idx_nxt;
			tx_len_r <= tx_len_nxt;
			tx_lsb_r <= tx_lsb_nxt;
			tx_pin_r <= tx_pin_nxt;
		end
	end

	// ==========================================================
	// Receiver: independent of the transmitter, own bit timing
	line_state_t rx_st_r, rx_st_nxt;
	logic [DATA_W-1:0] rx_sh_r, rx_sh_nxt;
	logic [4:0] rx_smp_r, rx_smp_nxt;
	logic [3:0] rx_idx_r, rx_idx_nxt;
	logic [3:0] rx_len_r, rx_len_nxt;
	logic rx_lsb_r, rx_lsb_nxt;
	logic rx_prev_r, cts_prev_r;
	logic rx_begin_ev, rx_word_ev, rx_frm_ev, rx_brk_ev, rx_fall;
	logic rx_mid, rx_end;

	assign rx_mid = tick && (rx_smp_r == half_pt);
	assign rx_end = tick && (rx_smp_r == sample_count);
	assign rx_fall = rx_prev_r && !data_pin_0;

	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_smp_nxt = rx_smp_r;
		rx_idx_nxt = rx_idx_r;
		rx_len_nxt = rx_len_r;
		rx_lsb_nxt = rx_lsb_r;
		rx_begin_ev = 1'b0;
		rx_word_ev = 1'b0;
		rx_frm_ev = 1'b0;
		rx_brk_ev = 1'b0;
		if (tick) begin
			rx_smp_nxt = rx_end ? 5'h00 : rx_smp_r + 5'h01;
		end
		unique case (rx_st_r)
			LN_IDLE: begin
				rx_smp_nxt = 5'h00;
				if (uart_on && rx_fall) begin
					rx_len_nxt = word_len;
					rx_lsb_nxt = lsb_first;
					rx_sh_nxt = '0;
					rx_st_nxt = LN_START;
				end
			end
			LN_START: begin
				if (rx_mid) begin
					if (data_pin_0) begin
						rx_st_nxt = LN_IDLE;
					end else begin
						rx_begin_ev = 1'b1;
					end
				end
				if (rx_end) begin
					rx_idx_nxt = 4'h0;
					rx_st_nxt = LN_DATA;
				end
			end
			LN_DATA: begin
				if (rx_mid) begin
					rx_sh_nxt[rx_idx_r] = data_pin_0;
				end
				if (rx_end) begin
					rx_idx_nxt = rx_idx_r + 4'h1;
					if (rx_idx_r == rx_len_r - 4'h1) begin
						rx_st_nxt = LN_STOP;
					end
				end
			end
			LN_STOP: begin
				// Word is taken at mid stop so a new start may follow at once
				if (rx_mid) begin
					rx_word_ev = 1'b1;
					rx_frm_ev = !data_pin_0;
					rx_brk_ev = !data_pin_0 && (rx_sh_r == '0);
					rx_st_nxt = LN_IDLE;
				end
			end
		endcase
		if (!uart_on) begin
			rx_st_nxt = LN_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_st_r <= LN_IDLE;
			rx_sh_r <= '0;
			rx_smp_r <= 5'h00;
			rx_idx_r <= 4'h0;
			rx_len_r <= `CH_LEN_RST;
			rx_lsb_r <= 1'b1;
			rx_prev_r <= 1'b1;
			cts_prev_r <= 1'b1;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_smp_r <= rx_smp_nxt;
			rx_idx_r <= rx_idx_nxt;
			rx_len_r <= rx_len_nxt;
			rx_lsb_r <= rx_lsb_nxt;
			rx_prev_r <= data_pin_0;
			cts_prev_r <= clear_to_send_n;
		end
	end

	logic rx_store;
	logic rx_drop;

	assign rx_store = rx_word_ev && !rxq.full;
	assign rx_drop = rx_word_ev && rxq.full;
	assign rxq.flush = !chan_on;
	assign rxq.push = rx_store;
	assign rxq.push_data = order_bits(rx_sh_r, rx_len_r, rx_lsb_r);
	assign rxq.push_err = rx_frm_ev;
	assign rxq.pop = rx_rd;

	// ==========================================================
	// Event flags, interrupts, DMA and wake-up
	logic [`CH_STS_W-1:0] sts_r, sts_nxt, sts_set, grp_mask;
	logic ovr_r, ovr_nxt;
	logic [4:0] irq_nxt;
	logic [4:0] irq_r;
	logic dma_tx_nxt, dma_rx_nxt, dma_tx_r, dma_rx_r;
	logic wake_nxt, wake_r;
	logic [DATA_W-1:0] rx_out_r;
	logic [`CH_BUF_STS_W-1:0] bsts_r, bsts_nxt;

	always_comb begin
		unique case (mode)
			MODE_UART: grp_mask = `CH_UART_LO_MASK | `CH_UART_HI_MASK;
			MODE_SPI: grp_mask = `CH_SPI_MASK;
			MODE_I2C: grp_mask = `CH_I2C_MASK;
			default: grp_mask = '0;
		endcase
		sts_set = proto_event_set & grp_mask;
		sts_set[`CH_TXB_BIT] = tx_begin_ev;
		sts_set[`CH_TXD_BIT] = tx_done_ev;
		sts_set[`CH_RXB_BIT] = rx_begin_ev;
		sts_set[`CH_RXD_BIT] = rx_store;
		sts_set[`CH_UART_FRM_BIT] = sts_set[`CH_UART_FRM_BIT] | rx_frm_ev;
		sts_set[`CH_UART_BRK_BIT] = sts_set[`CH_UART_BRK_BIT] | rx_brk_ev;
		// Set wins over a clear in the same cycle
		sts_nxt = (sts_r & ~status_clear) | sts_set;
		ovr_nxt = (ovr_r & !overrun_clear) | rx_drop;
		if (!chan_on) begin
			sts_nxt = '0;
			ovr_nxt = 1'b0;
		end
		irq_nxt[0] = sts_r[`CH_TXB_BIT] && tx_begin_irq_en;
		irq_nxt[1] = sts_r[`CH_TXD_BIT] && tx_done_irq_en;
		irq_nxt[2] = sts_r[`CH_RXB_BIT] && rx_begin_irq_en;
		irq_nxt[3] = sts_r[`CH_RXD_BIT] && rx_done_irq_en;
		irq_nxt[4] = ovr_r && rx_overrun_irq_en;
		unique case (mode)
			MODE_UART: begin
				irq_nxt[4] |= protocol_irq_enable_reg[`CH_PIE_UART_LO]
					&& |(sts_r & `CH_UART_LO_MASK);
				irq_nxt[4] |= protocol_irq_enable_reg[`CH_PIE_UART_HI]
					&& |(sts_r & `CH_UART_HI_MASK);
			end
			MODE_SPI: begin
				irq_nxt[4] |= protocol_irq_enable_reg[0] && sts_r[`CH_SPI_B0];
				irq_nxt[4] |= protocol_irq_enable_reg[1] && sts_r[`CH_SPI_B1];
				irq_nxt[4] |= protocol_irq_enable_reg[2] && sts_r[`CH_SPI_B2];
				irq_nxt[4] |= protocol_irq_enable_reg[3] && sts_r[`CH_SPI_B3];
			end
			MODE_I2C: begin
				irq_nxt[4] |= protocol_irq_enable_reg[0] && sts_r[`CH_I2C_B0];
				for (int i = 1; i < 7; i++) begin
					irq_nxt[4] |= protocol_irq_enable_reg[i] && sts_r[`CH_I2C_HI_BASE + i];
				end
			end
			default: begin
			end
		endcase
		dma_tx_nxt = chan_on && dma_master_en && dma_tx_req_en && !tx_buf_v_r;
		// Errored head word stalls the request until software reads it
		dma_rx_nxt = chan_on && dma_master_en && dma_rx_req_en && !rxq.empty
			&& !(uart_on && rxq.head_err);
		wake_nxt = uart_on && ((wake_data_en && rx_st_r == LN_IDLE && rx_fall)
			|| (wake_cts_en && (clear_to_send_n != cts_prev_r)));
		bsts_nxt = '0;
		bsts_nxt[`CH_RXEMPTY_BIT] = rxq.empty;
		bsts_nxt[`CH_RXFULL_BIT] = rxq.full;
		bsts_nxt[`CH_OVR_BIT] = ovr_r;
		bsts_nxt[`CH_TXEMPTY_BIT] = !tx_buf_v_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sts_r <= '0;
			ovr_r <= 1'b0;
			irq_r <= 5'h00;
			dma_tx_r <= 1'b0;
			dma_rx_r <= 1'b0;
			wake_r <= 1'b0;
			rx_out_r <= '0;
			bsts_r <= `CH_BSTS_RST;
		end else begin
			sts_r <= sts_nxt;
			ovr_r <= ovr_nxt;
			irq_r <= irq_nxt;
			dma_tx_r <= dma_tx_nxt;
			dma_rx_r <= dma_rx_nxt;
			wake_r <= wake_nxt;
			rx_out_r <= rxq.head_data;
			bsts_r <= bsts_nxt;
		end
	end

	assign data_pin_1 = tx_pin_r;
	assign protocol_status_reg = sts_r;
	assign buffer_status_reg = bsts_r;
	assign rx_data_reg = rx_out_r;
	assign irq_tx_begin = irq_r[0];
	assign irq_tx_done = irq_r[1];
	assign irq_rx_begin = irq_r[2];
	assign irq_rx_done = irq_r[3];
	assign irq_protocol = irq_r[4];
	assign dma_tx_req = dma_tx_r;
	assign dma_rx_req = dma_rx_r;
	assign wake_req = wake_r;
endmodule : serial_channel_events_dma

`default_nettype wire

//--- sim/remote_uart.sv
`timescale 1ns/1ns
`default_nettype none

module remote_uart #(
	parameter int BIT_CLKS = 8,
	parameter int WORD_BITS = 8
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out,
	output logic cts_n
);
	logic [WORD_BITS-1:0] rx_word;
	logic [WORD_BITS-1:0] got;
	int rx_count = 0;

	initial begin
		line_out = 1'b1;
		cts_n = 1'b0;
	end

	task automatic set_cts(input logic v);
		cts_n = v;
	endtask : set_cts

	// ==========================================================
	// Sender, lsb first, one stop bit whose level the caller picks
	task automatic send(input logic [WORD_BITS-1:0] w, input logic stop_v);
		line_out = 1'b0;
		repeat (BIT_CLKS) @(posedge clk);
		for (int i = 0; i < WORD_BITS; i++) begin
			#1 line_out = w[i];
			repeat (BIT_CLKS) @(posedge clk);
		end
		#1 line_out = stop_v;
		repeat (BIT_CLKS) @(posedge clk);
		#1 line_out = 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
		#1;
	endtask : send

	// ==========================================================
	// Receiver, mid-bit sampling from the start edge
	always begin : rx_frame
		@(negedge line_in);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < WORD_BITS; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			got[i] = line_in;
		end
		repeat (BIT_CLKS) @(posedge clk);
		rx_word = got;
		rx_count++;
	end
endmodule : remote_uart

`default_nettype wire

//--- sim/serial_channel_events_dma_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "chan_defs.svh"

module serial_channel_events_dma_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] function_select,
	input wire logic tx_begin_irq_en,
	input wire logic tx_done_irq_en,
	input wire logic rx_begin_irq_en,
	input wire logic dma_master_en,
	input wire logic [`CH_STS_W-1:0] status_clear,
	input wire logic [`CH_STS_W-1:0] proto_event_set,
	input wire logic data_pin_1,
	input wire logic [`CH_STS_W-1:0] protocol_status_reg,
	input wire logic [`CH_BUF_STS_W-1:0] buffer_status_reg,
	input wire logic irq_tx_begin,
	input wire logic irq_tx_done,
	input wire logic irq_rx_begin,
	input wire logic dma_tx_req,
	input wire logic dma_rx_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Interrupt outputs
	// Guarded by past reset: a one-edge reset leaves stale flags in $past
	a_irq_tx_begin: assert property ($past(rst_n) |->
		irq_tx_begin == $past(protocol_status_reg[1] && tx_begin_irq_en))
		else $error("tx begin irq does not follow flag and enable");
	a_irq_tx_done: assert property ($rose(irq_tx_done) |->
		$past(protocol_status_reg[2] && tx_done_irq_en))
		else $error("tx done irq rose without flag and enable");
	a_irq_rx_begin: assert property (protocol_status_reg[3] && rx_begin_irq_en &&
		function_select != 3'h0 |=> irq_rx_begin)
		else $error("rx begin irq missing");

	// ==========================================================
	// Flags
	a_flag_sticky: assert property (protocol_status_reg[4] && !status_clear[4] &&
		function_select != 3'h0 |=> protocol_status_reg[4])
		else $error("rx done flag dropped without clear");
	a_clear_event: assert property (status_clear[16] && !proto_event_set[16]
		|=> !protocol_status_reg[16])
		else $error("write one did not clear flag");
	a_mode_off: assert property (function_select == 3'h0 |=> protocol_status_reg == '0)
		else $error("flags survive channel off");
	a_txb_line: assert property ($rose(protocol_status_reg[1]) |-> !data_pin_1)
		else $error("tx begin flag without start bit");

	// ==========================================================
	// DMA requests
	a_dma_master: assert property (!dma_master_en [*2] |-> !dma_tx_req && !dma_rx_req)
		else $error("dma request while master disabled");
	a_rx_dma_empty: assert property (buffer_status_reg[0] [*2] |-> !dma_rx_req)
		else $error("rx dma request with empty buffer");

	c_overrun: cover property (buffer_status_reg[3]);
	c_frame_err: cover property (protocol_status_reg[6]);
	c_tx_start: cover property ($rose(protocol_status_reg[1]));
endmodule : serial_channel_events_dma_asserts

bind serial_channel_events_dma serial_channel_events_dma_asserts chk_u (.clk, .rst_n,
	.function_select, .tx_begin_irq_en, .tx_done_irq_en, .rx_begin_irq_en, .dma_master_en,
	.status_clear, .proto_event_set, .data_pin_1, .protocol_status_reg, .buffer_status_reg,
	.irq_tx_begin, .irq_tx_done, .irq_rx_begin, .dma_tx_req, .dma_rx_req);

`default_nettype wire

//--- sim/serial_channel_events_dma_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "chan_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module serial_channel_events_dma_tb import chan_pkg::*;;
	logic clk, rst_n, protocol_enable, tx_begin_irq_en, tx_done_irq_en, rx_begin_irq_en;
	logic rx_done_irq_en, rx_overrun_irq_en, dma_master_en, dma_tx_req_en, dma_rx_req_en;
	logic lsb_first, auto_flow_en, wake_data_en, wake_cts_en, tx_wr, rx_rd, overrun_clear;
	logic data_pin_0, control_pin_0, data_pin_1, irq_tx_begin, irq_tx_done, irq_rx_begin;
	logic irq_rx_done, irq_protocol, dma_tx_req, dma_rx_req, wake_req;
	logic [2:0] function_select;
	logic [6:0] protocol_irq_enable_reg;
	logic [1:0] sample_prediv;
	logic [4:0] sample_count;
	logic [3:0] word_len;
	logic [15:0] tx_wdata, rx_data_reg;
	logic [`CH_STS_W-1:0] status_clear, proto_event_set, protocol_status_reg;
	logic [`CH_BUF_STS_W-1:0] buffer_status_reg;
	int n_mismatch = 0;
	int cmp_count = 0;
	mode_t modes[4] = '{MODE_UART, MODE_UART, MODE_SPI, MODE_I2C};
	int pbit[4] = '{16, 5, 9, 13};
	int pen[4] = '{2, 1, 3, 6};

	serial_channel_events_dma dut_u (.clk, .rst_n, .function_select, .protocol_enable,
		.tx_begin_irq_en, .tx_done_irq_en, .rx_begin_irq_en, .rx_done_irq_en,
		.protocol_irq_enable_reg, .rx_overrun_irq_en, .dma_master_en, .dma_tx_req_en,
		.dma_rx_req_en, .sample_prediv, .sample_count, .word_len, .lsb_first, .auto_flow_en,
		.wake_data_en, .wake_cts_en, .tx_wr, .tx_wdata, .rx_rd, .status_clear, .overrun_clear,
		.proto_event_set, .data_pin_0, .control_pin_0, .data_pin_1, .protocol_status_reg,
		.buffer_status_reg, .rx_data_reg, .irq_tx_begin, .irq_tx_done, .irq_rx_begin,
		.irq_rx_done, .irq_protocol, .dma_tx_req, .dma_rx_req, .wake_req);
	remote_uart partner_u (.clk, .line_in(data_pin_1), .line_out(data_pin_0),
		.cts_n(control_pin_0));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Access tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic wait_on(input int b, input int n);
		int k;
		k = 0;
		while ((b >= 0 ? protocol_status_reg[b] !== 1'b1 : partner_u.rx_count < n) && k < 400) begin
			step(1);
			k++;
		end
		if (k == 400) begin
			n_mismatch++;
			stop_test();
		end
	endtask : wait_on
	task automatic tx_write(input logic [7:0] d);
		tx_wdata = {8'h00, d};
		tx_wr = 1'b1;
		step(1);
		tx_wr = 1'b0;
	endtask : tx_write
	task automatic rx_read;
		rx_rd = 1'b1;
		step(1);
		rx_rd = 1'b0;
		step(2);
	endtask : rx_read
	task automatic clear_sts(input logic [`CH_STS_W-1:0] m);
		status_clear = m;
		step(1);
		status_clear = '0;
	endtask : clear_sts

	initial begin
		{rst_n, protocol_enable, tx_wr, rx_rd, overrun_clear, auto_flow_en, lsb_first} = '0;
		{tx_begin_irq_en, tx_done_irq_en, rx_begin_irq_en, rx_done_irq_en} = '0;
		{rx_overrun_irq_en, dma_master_en, dma_tx_req_en, dma_rx_req_en} = '0;
		{wake_data_en, wake_cts_en, sample_prediv, protocol_irq_enable_reg} = '0;
		sample_count = 5'h07;
		word_len = 4'h8;
		{status_clear, proto_event_set, tx_wdata} = '0;
		function_select = MODE_OFF;
		step(6);
		rst_n = 1'b1;
		`CHK("buffer status", 9'h001, buffer_status_reg)
		function_select = MODE_UART;
		{protocol_enable, lsb_first} = 2'h3;
		{tx_begin_irq_en, tx_done_irq_en, rx_begin_irq_en, rx_done_irq_en} = 4'hF;
		{dma_master_en, dma_tx_req_en, dma_rx_req_en, rx_overrun_irq_en} = 4'hF;
		step(3);
		`CHK("tx dma request", 1'b1, dma_tx_req)
		tx_write(8'hA5);
		wait_on(`CH_TXB_BIT, 0);
		`CHK("start bit", 1'b0, data_pin_1)
		step(1);
		`CHK("tx begin irq", 1'b1, irq_tx_begin)
		wait_on(-1, 1);
		`CHK("tx word", 8'hA5, partner_u.rx_word)
		wait_on(`CH_TXD_BIT, 0);
		clear_sts(18'h00002);
		step(1);
		`CHK("begin cleared only", 2'b10, protocol_status_reg[2:1])
		`CHK("done irq held", 1'b1, irq_tx_done)
		tx_done_irq_en = 1'b0;
		step(2);
		`CHK("done irq masked", 1'b0, irq_tx_done)
		tx_done_irq_en = 1'b1;
		lsb_first = 1'b0;
		tx_write(8'h01);
		wait_on(`CH_TXB_BIT, 0);
		lsb_first = 1'b1;
		wait_on(-1, 2);
		`CHK("msb first held", 8'h80, partner_u.rx_word)
		$display("test tx finished");
		clear_sts(18'h00006);
		{auto_flow_en, wake_cts_en} = 2'b11;
		partner_u.set_cts(1'b1);
		tx_write(8'h3C);
		`CHK("cts wake", 1'b1, wake_req)
		step(40);
		`CHK("flow hold", 1'b0, protocol_status_reg[1])
		`CHK("tx buffer held", 1'b0, buffer_status_reg[`CH_TXEMPTY_BIT])
		partner_u.set_cts(1'b0);
		wait_on(-1, 3);
		`CHK("flow word", 8'h3C, partner_u.rx_word)
		auto_flow_en = 1'b0;
		$display("test flow finished");
		clear_sts(18'h3FFFF);
		partner_u.send(8'h11, 1'b1);
		`CHK("rx begin and done", 2'b11, protocol_status_reg[4:3])
		`CHK("rx irqs", 2'b11, {irq_rx_begin, irq_rx_done})
		`CHK("rx dma request", 1'b1, dma_rx_req)
		partner_u.send(8'h22, 1'b1);
		partner_u.send(8'h33, 1'b1);
		`CHK("overrun", 1'b1, buffer_status_reg[`CH_OVR_BIT])
		`CHK("rx full", 1'b1, buffer_status_reg[`CH_RXFULL_BIT])
		`CHK("overrun irq", 1'b1, irq_protocol)
		`CHK("first word", 16'h0011, rx_data_reg)
		dma_rx_req_en = 1'b0;
		rx_read();
		`CHK("rx dma disabled", 1'b0, dma_rx_req)
		`CHK("second word", 16'h0022, rx_data_reg)
		dma_rx_req_en = 1'b1;
		rx_read();
		`CHK("rx empty", 1'b1, buffer_status_reg[`CH_RXEMPTY_BIT])
		overrun_clear = 1'b1;
		step(1);
		overrun_clear = 1'b0;
		$display("test rx finished");
		clear_sts(18'h3FFFF);
		partner_u.send(8'h00, 1'b0);
		`CHK("frame error and break", 2'b11, protocol_status_reg[7:6])
		`CHK("proto irq masked", 1'b0, irq_protocol)
		{rx_begin_irq_en, rx_done_irq_en} = 2'b00;
		partner_u.send(8'h44, 1'b1);
		`CHK("rx irqs masked", 2'b00, {irq_rx_begin, irq_rx_done})
		`CHK("rx request held", 1'b0, dma_rx_req)
		rx_read();
		`CHK("next word", 16'h0044, rx_data_reg)
		`CHK("rx request resumed", 1'b1, dma_rx_req)
		rx_read();
		$display("test error finished");
		for (int i = 0; i < 4; i++) begin
			function_select = MODE_OFF;
			step(2);
			function_select = modes[i];
			proto_event_set = 18'h00001 << pbit[i];
			step(1);
			proto_event_set = '0;
			step(1);
			`CHK("proto flag", 1'b1, protocol_status_reg[pbit[i]])
			`CHK("proto irq off", 1'b0, irq_protocol)
			protocol_irq_enable_reg = 7'h01 << pen[i];
			step(2);
			`CHK("proto irq", 1'b1, irq_protocol)
			protocol_irq_enable_reg = '0;
			clear_sts(18'h00001 << pbit[i]);
			step(1);
			`CHK("proto flag cleared", 1'b0, protocol_status_reg[pbit[i]])
		end
		$display("test protocol finished");
		function_select = MODE_OFF;
		step(2);
		function_select = MODE_UART;
		dma_master_en = 1'b0;
		step(3);
		`CHK("tx request gated", 1'b0, dma_tx_req)
		dma_master_en = 1'b1;
		step(2);
		`CHK("tx request back", 1'b1, dma_tx_req)
		function_select = MODE_OFF;
		step(2);
		`CHK("channel off", 18'h0, protocol_status_reg)
		$display("test dma finished");
		stop_test();
	end
endmodule : serial_channel_events_dma_tb

`default_nettype wire
